// File: hw/tpio_defs.vh
// constants for the timer pin i/o control block
// assumes a 32-bit axi4-lite bus with byte addresses
`ifndef TPIO_DEFS_VH
`define TPIO_DEFS_VH

// ****************************************
// register map (byte addresses)
// ****************************************
`define TPIO_ADDR_W       8
`define TPIO_OFS_CH0_AB   8'h00
`define TPIO_OFS_CH0_CD   8'h04
`define TPIO_OFS_CH1      8'h08
`define TPIO_OFS_CH2      8'h0c
`define TPIO_OFS_CH3_AB   8'h10
`define TPIO_OFS_CH3_CD   8'h14
`define TPIO_OFS_CH4_AB   8'h18
`define TPIO_OFS_CH4_CD   8'h1c
`define TPIO_OFS_RUN_BUF  8'h20
`define TPIO_OFS_PIN_STAT 8'h24

// ****************************************
// field layout
// ****************************************
`define TPIO_NUM_CTRL     8
`define TPIO_NUM_GR       16
`define TPIO_FLD_CAPT     3
`define TPIO_FLD_INIT     2
`define TPIO_FLD_CASC     2
`define TPIO_FLD_BOTH     1
`define TPIO_RUN_LSB      0
`define TPIO_BFA_LSB      8
`define TPIO_BFB_LSB      12
`define TPIO_CTRL_RESET   8'h00
`define TPIO_RUN_RESET    5'h00
`define TPIO_BUF_RESET    3'h0

// ****************************************
// general register indices
// ****************************************
`define TPIO_GR_CH0_A     0
`define TPIO_GR_CH0_C     2
`define TPIO_GR_CH1_A     4
`define TPIO_GR_CH1_B     5
`define TPIO_GR_CH2_A     6

// ****************************************
// bus answers
// ****************************************
`define TPIO_RESP_OKAY    2'h0
`define TPIO_RESP_SLVERR  2'h2

`endif

// File: hw/tpio_top.v
// pin i/o control for general registers of timer channels 0 to 4, axi4-lite slave
// assumes match_in and ch1_count_pulse are one-cycle pulses from the timer core,
// pin_in is synchronous to sys_clk
// Overview of operation
// - compare code 0x01 drives pin low on match; bit 2 sets initial level.
// - compare code 0x10 drives pin high on every match.
// - compare code 0x11 toggles pin on every match.
// - after reset every pin is driven low until software sets it.
// - capture code 1x00 latches on rising edge; bit 2 ignored on channels 2-4.
// - capture code 1x01 latches on falling pin edge.
// - capture code 1x1x latches on both pin edges.
// - channel 0 code 11xx captures whenever the channel 1 counter counts.
// - channel 1 register b code 11xx captures on channel 0 register c event.
// - channel 1 register a code 11xx captures on channel 0 register a event.
// - buffer-b enable makes register d inert: no capture, no compare.
// - buffer-a enable makes register c inert: no capture, no compare.
// - initial pin level is driven only while the channel start bit is 0.
//
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`include "tpio_defs.vh"

module tpio_top (
	input  wire                    sys_clk,          // 20 mhz clock
	input  wire                    rst_n,            // async reset, active low
	input  wire [`TPIO_ADDR_W-1:0] s_axi_awaddr,     // write address
	input  wire                    s_axi_awvalid,    // write address valid
	output wire                    s_axi_awready,    // write address ready
	input  wire [31:0]             s_axi_wdata,      // write data
	input  wire [3:0]              s_axi_wstrb,      // write byte strobes
	input  wire                    s_axi_wvalid,     // write data valid
	output wire                    s_axi_wready,     // write data ready
	output wire [1:0]              s_axi_bresp,      // write response
	output wire                    s_axi_bvalid,     // write response valid
	input  wire                    s_axi_bready,     // write response ready
	input  wire [`TPIO_ADDR_W-1:0] s_axi_araddr,     // read address
	input  wire                    s_axi_arvalid,    // read address valid
	output wire                    s_axi_arready,    // read address ready
	output wire [31:0]             s_axi_rdata,      // read data
	output wire [1:0]              s_axi_rresp,      // read response
	output wire                    s_axi_rvalid,     // read data valid
	input  wire                    s_axi_rready,     // read data ready
	input  wire [15:0]             match_in,         // counter equals general register
	input  wire                    ch1_count_pulse,  // channel 1 counter counted
	input  wire [15:0]             pin_in,           // timer pin levels
	output wire [15:0]             pin_out,          // timer pin drive level
	output wire [15:0]             pin_oe_n,         // pin output enable, active low
	output wire [15:0]             capture_strobe,   // latch counter into register
	output wire [15:0]             event_strobe      // compare match or capture taken
);

	// ****************************************
	// helpers
	// ****************************************
	// general register i sits in control byte i/2, nibble i%2
	function [3:0] field_of;
		input [63:0] regs;
		input integer i;
		begin
			field_of = regs[i*4 +: 4];
		end
	endfunction

	function [2:0] chan_of;
		input integer i;
		begin
			if (i < 4)
				chan_of = 3'h0;
			else if (i < 6)
				chan_of = 3'h1;
			else if (i < 8)
				chan_of = 3'h2;
			else if (i < 12)
				chan_of = 3'h3;
			else
				chan_of = 3'h4;
		end
	endfunction

	// register kinds behind a byte address, shared by both decoders
	localparam [1:0] KIND_CTRL = 2'h0;
	localparam [1:0] KIND_RUN  = 2'h1;
	localparam [1:0] KIND_STAT = 2'h2;
	localparam [1:0] KIND_NONE = 2'h3;

	function [1:0] kind_of;
		input [`TPIO_ADDR_W-1:0] addr;
		begin
			if (addr[7:2] < `TPIO_NUM_CTRL)
				kind_of = KIND_CTRL;
			else if (addr[7:2] == `TPIO_OFS_RUN_BUF >> 2)
				kind_of = KIND_RUN;
			else if (addr[7:2] == `TPIO_OFS_PIN_STAT >> 2)
				kind_of = KIND_STAT;
			else
				kind_of = KIND_NONE;
		end
	endfunction

	// event of one channel 0 register, same decode as the per register loop
	function reg_event;
		input [3:0] fld_v;
		input       inert_v;
		input       run_v;
		input       match_v;
		input       rise_v;
		input       fall_v;
		input       casc_v;
		begin
			if (inert_v || !run_v)
				reg_event = 1'b0;
			else if (!fld_v[`TPIO_FLD_CAPT])
				reg_event = match_v;
			else if (fld_v[`TPIO_FLD_CASC])
				reg_event = casc_v;
			else if (fld_v[`TPIO_FLD_BOTH])
				reg_event = rise_v | fall_v;
			else if (fld_v[0])
				reg_event = fall_v;
			else
				reg_event = rise_v;
		end
	endfunction

	// ****************************************
	// state
	// ****************************************
	reg  [63:0] ctrl_q;
	reg  [4:0]  run_q;
	reg  [2:0]  bfa_q;
	reg  [2:0]  bfb_q;
	reg  [15:0] pin_prev_q;
	reg  [15:0] pin_q;
	reg  [15:0] pin_d;
	reg  [15:0] oe_n_q;
	reg  [15:0] oe_n_d;
	reg  [15:0] capt_q;
	reg  [15:0] capt_d;
	reg  [15:0] ev_q;
	reg  [15:0] ev_d;
	reg         awready_q;
	reg         wready_q;
	reg         aw_have_q;
	reg         w_have_q;
	reg  [7:0]  waddr_q;
	reg  [31:0] wdata_q;
	reg  [3:0]  wstrb_q;
	reg         bvalid_q;
	reg  [1:0]  bresp_q;
	reg         arready_q;
	reg         rvalid_q;
	reg  [31:0] rdata_q;
	reg  [1:0]  rresp_q;
	wire [15:0] rise;
	wire [15:0] fall;
	wire [15:0] inert;
	wire        src_a_ev;
	wire        src_c_ev;

	assign rise = pin_in & ~pin_prev_q;
	assign fall = ~pin_in & pin_prev_q;
	// buffer roles of c and d on channels 0, 3 and 4
	assign inert = {bfb_q[2], bfa_q[2], 2'h0, bfb_q[1], bfa_q[1], 6'h00,
		bfb_q[0], bfa_q[0], 2'h0};

	// ch1 cascade sources, ahead of the loop so it never reads its own events
	assign src_a_ev = reg_event(field_of(ctrl_q, `TPIO_GR_CH0_A), inert[0], run_q[0],
		match_in[0], rise[0], fall[0], ch1_count_pulse);
	assign src_c_ev = reg_event(field_of(ctrl_q, `TPIO_GR_CH0_C), inert[2], run_q[0],
		match_in[2], rise[2], fall[2], ch1_count_pulse);

	// ****************************************
	// per register pin, capture and compare logic
	// ****************************************
	integer i;
	reg [3:0] fld;
	reg       run;
	reg       trig;

	always @* begin
		fld    = 4'h0;
		run    = 1'b0;
		trig   = 1'b0;
		pin_d  = pin_q;
		oe_n_d = oe_n_q;
		capt_d = 16'h0000;
		ev_d   = 16'h0000;
		for (i = 0; i < `TPIO_NUM_GR; i = i + 1) begin
			fld  = field_of(ctrl_q, i);
			run  = run_q[chan_of(i)];
			trig = 1'b0;
			if (inert[i]) begin
				// buffered register keeps pin and makes no events
				oe_n_d[i] = oe_n_q[i];
			end else if (fld[`TPIO_FLD_CAPT]) begin
				oe_n_d[i] = 1'b1;
				if (fld[`TPIO_FLD_CASC] && (i < `TPIO_GR_CH2_A)) begin
					if (i < `TPIO_GR_CH1_A)
						trig = ch1_count_pulse;
					else if (i == `TPIO_GR_CH1_A)
						trig = src_a_ev;
					else
						trig = src_c_ev;
				end else if (fld[`TPIO_FLD_BOTH]) begin
					trig = rise[i] | fall[i];
				end else if (fld[0]) begin
					trig = fall[i];
				end else begin
					trig = rise[i];
				end
				capt_d[i] = trig & run;
				ev_d[i]   = trig & run;
			end else begin
				oe_n_d[i] = 1'b0;
				if (!run) begin
					if (fld[1:0] != 2'h0)
						pin_d[i] = fld[`TPIO_FLD_INIT];
				end else if (match_in[i]) begin
					ev_d[i] = 1'b1;
					case (fld[1:0])
						2'h1: pin_d[i] = 1'b0;
						2'h2: pin_d[i] = 1'b1;
						2'h3: pin_d[i] = ~pin_q[i];
						default: pin_d[i] = pin_q[i];
					endcase
				end
			end
		end
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_prev_q <= 16'h0000;
			pin_q      <= 16'h0000;
			oe_n_q     <= 16'h0000;
			capt_q     <= 16'h0000;
			ev_q       <= 16'h0000;
		end else begin
			pin_prev_q <= pin_in;
			pin_q      <= pin_d;
			oe_n_q     <= oe_n_d;
			capt_q     <= capt_d;
			ev_q       <= ev_d;
		end
	end

	// ****************************************
	// axi4-lite write channel
	// ****************************************
	integer k;
	wire do_write;
	assign do_write = aw_have_q & w_have_q & ~bvalid_q;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			waddr_q   <= 8'h00;
			wdata_q   <= 32'h00000000;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `TPIO_RESP_OKAY;
			ctrl_q    <= {8{`TPIO_CTRL_RESET}};
			run_q     <= `TPIO_RUN_RESET;
			bfa_q     <= `TPIO_BUF_RESET;
			bfb_q     <= `TPIO_BUF_RESET;
		end else begin
			if (awready_q && s_axi_awvalid) begin
				awready_q <= 1'b0;
				aw_have_q <= 1'b1;
				waddr_q   <= s_axi_awaddr;
			end else if (!aw_have_q && !bvalid_q) begin
				awready_q <= 1'b1;
			end
			if (wready_q && s_axi_wvalid) begin
				wready_q <= 1'b0;
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end else if (!w_have_q && !bvalid_q) begin
				wready_q <= 1'b1;
			end
			if (do_write) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= `TPIO_RESP_OKAY;
				if (kind_of(waddr_q) == KIND_CTRL) begin
					for (k = 0; k < `TPIO_NUM_CTRL; k = k + 1)
						if ((waddr_q[7:2] == k) && wstrb_q[0])
							ctrl_q[k*8 +: 8] <= wdata_q[7:0];
				end else if (kind_of(waddr_q) == KIND_RUN) begin
					if (wstrb_q[0])
						run_q <= wdata_q[`TPIO_RUN_LSB +: 5];
					if (wstrb_q[1]) begin
						bfa_q <= wdata_q[`TPIO_BFA_LSB +: 3];
						bfb_q <= wdata_q[`TPIO_BFB_LSB +: 3];
					end
				end else if (kind_of(waddr_q) == KIND_NONE) begin
					bresp_q <= `TPIO_RESP_SLVERR;
				end
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// axi4-lite read channel
	// ****************************************
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h00000000;
			rresp_q   <= `TPIO_RESP_OKAY;
		end else begin
			if (arready_q && s_axi_arvalid) begin
				arready_q <= 1'b0;
				rvalid_q  <= 1'b1;
				rresp_q   <= `TPIO_RESP_OKAY;
				rdata_q   <= 32'h00000000;
				if (kind_of(s_axi_araddr) == KIND_CTRL)
					rdata_q[7:0] <= ctrl_q[s_axi_araddr[4:2]*8 +: 8];
				else if (kind_of(s_axi_araddr) == KIND_RUN)
					rdata_q <= {17'h00000, bfb_q, 1'b0, bfa_q, 3'h0, run_q};
				else if (kind_of(s_axi_araddr) == KIND_STAT)
					rdata_q <= {~oe_n_q, pin_q};
				else
					rresp_q <= `TPIO_RESP_SLVERR;
			end else if (rvalid_q && s_axi_rready) begin
				rvalid_q  <= 1'b0;
				arready_q <= 1'b1;
			end else if (!rvalid_q) begin
				arready_q <= 1'b1;
			end
		end
	end

	assign s_axi_awready  = awready_q;
	assign s_axi_wready   = wready_q;
	assign s_axi_bresp    = bresp_q;
	assign s_axi_bvalid   = bvalid_q;
	assign s_axi_arready  = arready_q;
	assign s_axi_rdata    = rdata_q;
	assign s_axi_rresp    = rresp_q;
	assign s_axi_rvalid   = rvalid_q;
	assign pin_out        = pin_q;
	assign pin_oe_n       = oe_n_q;
	assign capture_strobe = capt_q;
	assign event_strobe   = ev_q;

endmodule

// File: test/tpio_pins.sv
// pin-side model of the timer pins
// assumes the bench sets the outside level applied to undriven pins
`timescale 1ns/100ps
module tpio_pins (
	input  wire [15:0] pin_out,  // block drive level
	input  wire [15:0] pin_oe_n, // 0 where block drives
	input  wire [15:0] ext_lvl,  // outside level
	output wire [15:0] pin_in    // level on the wire
);
	// a driven pin reads back its own level, so no false edges
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_lvl);
endmodule

// File: test/tpio_props.sv
// assertions on the ports of the pin i/o control block
// assumes binding to tpio_top, one clock, active low reset
`timescale 1ns/100ps
module tpio_props (
	input wire        sys_clk,        // clock
	input wire        rst_n,          // reset
	input wire        s_axi_awvalid,  // aw valid
	input wire        s_axi_awready,  // aw ready
	input wire        s_axi_wvalid,   // w valid
	input wire        s_axi_wready,   // w ready
	input wire [1:0]  s_axi_bresp,    // b code
	input wire        s_axi_bvalid,   // b valid
	input wire        s_axi_bready,   // b ready
	input wire        s_axi_arvalid,  // ar valid
	input wire        s_axi_arready,  // ar ready
	input wire [31:0] s_axi_rdata,    // read data
	input wire        s_axi_rvalid,   // r valid
	input wire        s_axi_rready,   // r ready
	input wire [15:0] match_in,       // matches
	input wire [15:0] pin_oe_n,       // drive enables
	input wire [15:0] capture_strobe, // captures
	input wire [15:0] event_strobe    // events
);
	// ****************************
	// bus and pin checks
	// ****************************
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	wr_answer_a: assert property (wr_take |=> ##1 s_axi_bvalid)
		else $error("write answer late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	aw_busy_a: assert property (wr_take |=> !s_axi_awready [*2])
		else $error("second write taken early");
	rd_answer_a: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	cap_event_a: assert property ((capture_strobe & ~event_strobe) == 16'h0)
		else $error("capture without event");
	cmp_event_a: assert property ((event_strobe & ~pin_oe_n & ~$past(match_in)) == 16'h0)
		else $error("compare event without match");
	cap_undriven_a: assert property ((capture_strobe & ~pin_oe_n) == 16'h0)
		else $error("capture on a driven pin");
endmodule
bind tpio_top tpio_props u_props (.*);

// File: test/tpio_top_tb.sv
// self-checking bench for the timer pin i/o control block
// assumes the pin model closes the loop between pin_out and pin_in
`timescale 1ns/100ps
module tpio_top_tb;
	reg         sys_clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
	reg         arvalid = 0, rready = 0, cnt1 = 0, p, pv, e;
	reg  [7:0]  awaddr = 0, araddr = 0, a;
	reg  [31:0] wdata = 0, lfsr = 32'heee3;
	reg  [31:0] m [0:9];
	reg  [15:0] match = 0, ext = 0;
	reg  [4:0]  c;
	wire        awready, wready, bvalid, arready, rvalid;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	wire [15:0] pin_in, pin_out, oe_n, cap, evt;
	integer     fail_count = 0, cmp_count = 0, cyc = 0, k;
	tpio_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .match_in(match), .ch1_count_pulse(cnt1),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(oe_n),
		.capture_strobe(cap), .event_strobe(evt));
	tpio_pins pins (.pin_out(pin_out), .pin_oe_n(oe_n), .ext_lvl(ext), .pin_in(pin_in));
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 5000) begin
			fail_count = fail_count + 1;
			close_out;
		end
	end
	// ****************************
	// model and bus tasks
	// ****************************
	function [31:0] nx(input [31:0] s);
		nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function cmp_f(input [3:0] f, input q);
		cmp_f = f[1:0] == 0 ? q : f[1:0] == 3 ? !q : f[1];
	endfunction
	function cap_f(input [3:0] f, input o, input n);
		cap_f = f[1] ? o ^ n : f[0] ? o & !n : !o & n;
	endfunction
	task close_out;
		begin
			if (fail_count == 0 && cmp_count > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("[FAIL] %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [7:0] ad, input [31:0] d, input [1:0] er);
		begin
			@(posedge sys_clk);
			awaddr <= ad;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			do begin
				@(posedge sys_clk);
				if (awready) awvalid <= 1'b0;
				if (wready) wvalid <= 1'b0;
			end while (!bvalid);
			bready <= 1'b0;
			chk(bresp, er);
			if (er == 0 && ad < 8'h24) m[ad[7:2]] = ad == 8'h20 ? d & 32'h771f : d & 32'hff;
		end
	endtask
	task rd(input [7:0] ad, input [1:0] er);
		begin
			@(posedge sys_clk);
			araddr <= ad;
			arvalid <= 1'b1;
			rready <= 1'b1;
			do begin
				@(posedge sys_clk);
				if (arready) arvalid <= 1'b0;
			end while (!rvalid);
			rready <= 1'b0;
			chk(rresp, er);
			chk(rdata, er ? 32'h0 : m[ad[7:2]]);
		end
	endtask
	// strobes show one edge after the inputs are driven
	task pulse(input [15:0] mt, input c1);
		begin
			@(posedge sys_clk);
			match <= mt;
			cnt1 <= c1;
			@(posedge sys_clk);
			match <= 16'h0;
			cnt1 <= 1'b0;
			#1;
		end
	endtask
	// ****************************
	// scenarios
	// ****************************
	initial begin
		for (k = 0; k < 10; k = k + 1) m[k] = 0;
		repeat (20) @(posedge sys_clk);
		chk({pin_out, oe_n}, 32'h0);
		rst_n <= 1'b1;
		for (a = 0; a < 8'h24; a = a + 4) rd(a, 0);
		rd(8'h28, 2);
		wr(8'h28, 32'h5, 2);
		chk(pin_out, 0);
		p = 0;
		for (c = 0; c < 8; c = c + 1) begin
			wr(8'h0c, c, 0);
			pulse(0, 0);
			if (c[1:0] != 0) p = c[2];
			chk({oe_n[6], pin_out[6]}, {1'b0, p});
			wr(8'h20, 32'h4, 0);
			lfsr = nx(lfsr);
			// stopped channels 3 and 4 must ignore stray matches
			repeat (1 + lfsr[1:0]) begin
				pulse(16'h40 | (lfsr[15:0] & 16'hff00), 0);
				p = cmp_f(c[3:0], p);
				chk({evt, 15'h0, pin_out[6]}, {16'h40, 15'h0, p});
			end
			wr(8'h20, 32'h0, 0);
			if (c[1:0] != 0) p = c[2];
		end
		wr(8'h20, 32'h4, 0);
		for (c = 8; c < 16; c = c + 1) begin
			wr(8'h0c, c, 0);
			pulse(0, 0);
			pv = pin_in[6];
			for (k = 0; k < 6; k = k + 1) begin
				lfsr = nx(lfsr);
				@(posedge sys_clk);
				ext <= lfsr[15:0];
				@(posedge sys_clk);
				#1;
				e = cap_f(c[3:0], pv, lfsr[6]);
				pv = lfsr[6];
				chk({cap, evt}, {2{9'h0, e, 6'h0}});
			end
		end
		wr(8'h00, 32'h0c, 0);
		wr(8'h04, 32'h33, 0);
		wr(8'h08, 32'hcc, 0);
		wr(8'h20, 32'h3, 0);
		pulse(0, 1);
		chk({cap, evt}, {16'h11, 16'h11});
		pulse(16'hc, 0);
		chk({cap, evt}, {16'h20, 16'h2c});
		chk(pin_out[3:2], 2'h3);
		wr(8'h20, 32'h1103, 0);
		pulse(16'hc, 0);
		chk({cap, evt}, 32'h0);
		chk(pin_out[3:2], 2'h3);
		wr(8'h24, 32'hffff, 0);
		m[9] = {16'hff8e, 9'h0, p, 6'h0c};
		rd(8'h24, 0);
		for (a = 0; a < 8'h24; a = a + 4) rd(a, 0);
		close_out;
	end
endmodule
